// [qste_engine.sv]
/*
 queue set traversal engine: fetches heads, judges, overlays, builds
 the active list, then writes back group results. assumes a memory
 agent serving req/resp and an executor that runs each group.
*/
`timescale 1ns/100ps
`default_nettype none
module qste_engine
#(
    parameter int MAX_GRP = qste_pkg::MAX_GRP
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic start_async,
    input wire qste_pkg::qste_link_t zone_link,
    input wire logic [7:0] zone_num,
    input wire logic async_ptr_wr,
    input wire qste_pkg::qste_link_t async_ptr_wdata,
    output qste_pkg::qste_link_t async_list_pointer_reg,
    input wire logic [qste_pkg::DEV_N-1:0] dev_unavail,
    input wire logic [qste_pkg::DEV_N-1:0] dev_disabled,
    output logic req_valid,
    output qste_pkg::qste_req_t req,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire qste_pkg::qste_resp_t resp,
    output logic act_valid,
    output qste_pkg::qste_ent_t act_ent,
    output logic grp_start,
    output logic [qste_pkg::IDX_W-1:0] grp_count,
    input wire logic res_valid,
    input wire qste_pkg::qste_res_t res,
    output logic res_ready,
    input wire logic grp_end,
    output logic busy,
    output logic pass_done
);
    import qste_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_QH_REQ, S_QH_WAIT, S_JUDGE, S_TD_REQ, S_TD_WAIT,
        S_OVL, S_ADD, S_FOLLOW, S_EXEC, S_RES, S_RD, S_WB
    } qste_state_t;

    qste_state_t state_q;
    qste_link_t link_q;
    qste_link_t aptr_q;
    qste_qh_t qh_q;
    qste_ovl_t ovl_q;
    qste_ovl_t ovl_d;
    qste_wb_t wb_q;
    qste_wb_t wb_d;
    qste_res_t res_q;
    qste_ent_t ent_wr;
    qste_ent_t ent_rd;
    qste_ent_t act_q;
    logic [$bits(qste_ent_t)-1:0] ent_raw;
    logic [IDX_W-1:0] n_q;
    logic [31:0] first_q;
    logic [7:0] zone_q;
    logic [7:0] nxt;
    logic async_q;
    logic more_q;
    logic add_blank_q;
    logic done_q;
    logic act_v_q;
    logic cand;
    logic first;
    logic blank_need;
    logic iso;
    logic follow_ok;
    logic grp_full;

    qste_judge u_judge (
        .qh(qh_q),
        .link_iso(link_q.iso),
        .is_async(async_q),
        .zone(zone_q),
        .dev_unavail(dev_unavail),
        .dev_disabled(dev_disabled),
        .cand(cand),
        .first(first),
        .blank_need(blank_need),
        .iso(iso)
    );

    // async: stop on return to the first set met; periodic: on terminate
    assign follow_ok = async_q ? (qh_q.next.ptr != first_q)
                               : !qh_q.next.term;
    assign grp_full = (n_q == IDX_W'(MAX_GRP));

    always_comb
    begin
        ent_wr = '0;
        ent_wr.qs = link_q.ptr;
        ent_wr.count = link_q.count;
        ent_wr.cur = qh_q.cur;
        ent_wr.status = qh_q.status;
        ent_wr.tx_cnt = first ? 8'h00 : qh_q.tx_cnt;
        ent_wr.max_cnt = qh_q.max_cnt;
        ent_wr.periodic = qh_q.periodic;
        ent_wr.dir_in = qh_q.dir_in;
        ent_wr.blank = add_blank_q;
        ent_wr.blank_done = first ? 1'b0 : qh_q.blank_done;
        ent_wr.iso = iso;
    end

    qste_mem #(.W($bits(qste_ent_t)), .DEPTH(1 << IDX_W)) u_list (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .we(state_q == S_ADD),
        .waddr(n_q),
        .wdata(ent_wr),
        .raddr(res.idx),
        .rdata(ent_raw)
    );
    assign ent_rd = qste_ent_t'(ent_raw);

    always_comb
    begin
        ovl_d = '0;
        ovl_d.full = !qh_q.react;
        ovl_d.dw0 = resp.td.dw0;
        ovl_d.body = resp.td.body;
        ovl_d.pres = resp.td.pres;
        if (iso && qh_q.dir_in)
            ovl_d.pres = qh_q.pres + PRES_STEP;
        if (qh_q.ctrl && !qh_q.react)
        begin
            ovl_d.win_rst = 1'b1;
            ovl_d.window = low_ones(qh_q.burst);
            ovl_d.seq = SEQ_RST;
            ovl_d.setup = 1'b1;
        end
    end

    always_comb
    begin
        nxt = ent_rd.cur + 8'h01;
        wb_d = '0;
        wb_d.qs = ent_rd.qs;
        wb_d.td = ent_rd.cur;
        wb_d.cur = ent_rd.cur;
        // sticky: error bits are ORed in and never cleared here
        wb_d.status = ent_rd.status | res_q.err;
        wb_d.tx_cnt = ent_rd.tx_cnt + {7'h00, res_q.txn};
        wb_d.zone = zone_q;
        wb_d.flow = res_q.flow;
        wb_d.blank_done = ent_rd.blank_done | ent_rd.blank;
        wb_d.done = res_q.done;
        if (res_q.done && res_q.ok)
            wb_d.cur = (ent_rd.cur >= ent_rd.count) ? IDX_RST : nxt;
        else if (res_q.done)
            wb_d.halt = 1'b1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= S_IDLE;
            link_q <= '0;
            qh_q <= '0;
            ovl_q <= '0;
            wb_q <= '0;
            res_q <= '0;
            n_q <= CNT_RST;
            first_q <= '0;
            zone_q <= ZONE_RST;
            async_q <= 1'b0;
            more_q <= 1'b0;
            add_blank_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            done_q <= 1'b0;
            case (state_q)
            S_IDLE:
                if (start)
                begin
                    async_q <= start_async;
                    zone_q <= zone_num;
                    link_q <= start_async ? aptr_q : zone_link;
                    first_q <= aptr_q.ptr;
                    n_q <= CNT_RST;
                    state_q <= S_QH_REQ;
                end
            S_QH_REQ:
                if (req_ready)
                    state_q <= S_QH_WAIT;
            S_QH_WAIT:
                if (resp_valid)
                begin
                    qh_q <= resp.qh;
                    state_q <= S_JUDGE;
                end
            S_JUDGE:
                if (!cand)
                    state_q <= S_FOLLOW;
                else if (qh_q.active)
                begin
                    add_blank_q <= 1'b0;
                    state_q <= S_ADD;
                end
                else
                    state_q <= S_TD_REQ;
            S_TD_REQ:
                if (req_ready)
                    state_q <= S_TD_WAIT;
            S_TD_WAIT:
                if (resp_valid)
                begin
                    if (resp.td.active)
                    begin
                        ovl_q <= ovl_d;
                        state_q <= S_OVL;
                    end
                    else if (blank_need)
                    begin
                        add_blank_q <= 1'b1;
                        state_q <= S_ADD;
                    end
                    else
                        state_q <= S_FOLLOW;
                end
            S_OVL:
                if (req_ready)
                begin
                    add_blank_q <= 1'b0;
                    state_q <= S_ADD;
                end
            S_ADD:
            begin
                n_q <= n_q + 4'h1;
                state_q <= S_FOLLOW;
            end
            S_FOLLOW:
            begin
                link_q <= qh_q.next;
                more_q <= follow_ok;
                if (follow_ok && !grp_full)
                    state_q <= S_QH_REQ;
                else if (n_q == CNT_RST)
                begin
                    done_q <= 1'b1;
                    state_q <= S_IDLE;
                end
                else
                    state_q <= S_EXEC;
            end
            S_EXEC:
                state_q <= S_RES;
            S_RES:
                if (res_valid)
                begin
                    res_q <= res;
                    state_q <= S_RD;
                end
                else if (grp_end)
                begin
                    n_q <= CNT_RST;
                    if (more_q)
                        state_q <= S_QH_REQ;
                    else
                    begin
                        done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
            S_RD:
            begin
                wb_q <= wb_d;
                state_q <= S_WB;
            end
            S_WB:
                if (req_ready)
                    state_q <= S_RES;
            default:
                state_q <= S_IDLE;
            endcase
        end
    end

    // software may load the pointer only while traversal is idle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            aptr_q <= '0;
        else if (clk_en)
        begin
            if (state_q == S_FOLLOW && async_q)
                aptr_q <= qh_q.next;
            else if (async_ptr_wr && state_q == S_IDLE)
                aptr_q <= async_ptr_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            act_v_q <= 1'b0;
            act_q <= '0;
        end
        else if (clk_en)
        begin
            act_v_q <= (state_q == S_ADD);
            if (state_q == S_ADD)
                act_q <= ent_wr;
        end
    end

    always_comb
    begin
        req = '0;
        req.iso = iso;
        req.addr = link_q.ptr;
        case (state_q)
        S_QH_REQ:
            req.op = OP_RD_QH;
        S_TD_REQ:
        begin
            req.op = OP_RD_TD;
            req.idx = qh_q.cur;
        end
        S_OVL:
        begin
            req.op = OP_WR_OVL;
            req.ovl = ovl_q;
        end
        S_WB:
        begin
            req.op = OP_WR_RES;
            req.addr = wb_q.qs;
            req.idx = wb_q.td;
            req.wb = wb_q;
        end
        default:
            req.op = OP_RD_QH;
        endcase
    end

    assign req_valid = (state_q == S_QH_REQ) || (state_q == S_TD_REQ)
        || (state_q == S_OVL) || (state_q == S_WB);
    assign res_ready = (state_q == S_RES);
    assign grp_start = (state_q == S_EXEC);
    assign grp_count = n_q;
    assign act_valid = act_v_q;
    assign act_ent = act_q;
    assign busy = (state_q != S_IDLE);
    assign pass_done = done_q;
    assign async_list_pointer_reg = aptr_q;

    // frozen cycles are skipped so the relations stay cycle-exact
    default clocking cb @(posedge sys_clk iff clk_en);
    endclocking
    default disable iff (rst);

    sequence s_td_fetch;
        state_q == S_TD_REQ;
    endsequence

    a_excluded_skip: assert property (
        state_q == S_JUDGE && !cand |=> state_q == S_FOLLOW)
        else $error("excluded head not skipped");
    a_td_fetch_start: assert property (
        state_q == S_JUDGE && cand && !qh_q.active |=> s_td_fetch)
        else $error("current descriptor not fetched");
    a_overlay_kind: assert property (
        req_valid && req.op == OP_WR_OVL |-> req.ovl.full == !qh_q.react)
        else $error("overlay extent wrong");
    a_ctrl_window: assert property (
        req_valid && req.op == OP_WR_OVL && req.ovl.setup
        |-> req.ovl.window == low_ones(qh_q.burst)
            && req.ovl.seq == SEQ_RST)
        else $error("control window not reset");
    a_index_advance: assert property (
        state_q == S_RD && res_q.done && res_q.ok |=> wb_q.cur ==
        (($past(ent_rd.cur) >= $past(ent_rd.count)) ? IDX_RST
            : $past(ent_rd.cur) + 8'h01))
        else $error("index advance wrong");
    a_halt_hold: assert property (
        state_q == S_RD && res_q.done && !res_q.ok
        |=> wb_q.halt && wb_q.cur == $past(ent_rd.cur))
        else $error("failed transfer not halted");
    a_status_sticky: assert property (
        state_q == S_RD |=> (wb_q.status & $past(ent_rd.status))
            == $past(ent_rd.status))
        else $error("error bits lost");
    a_flow_flag: assert property (
        state_q == S_RD && res_q.flow |=> req_valid && req.wb.flow)
        else $error("flow flag not set");
    a_async_keep: assert property (
        state_q == S_FOLLOW && async_q
        |=> async_list_pointer_reg == $past(qh_q.next))
        else $error("async pointer not kept");
    a_list_wrap: assert property (
        state_q == S_FOLLOW && async_q && qh_q.next.ptr == first_q
        |=> state_q != S_QH_REQ)
        else $error("async list walked twice");
    a_group_bound: assert property (
        state_q == S_FOLLOW && grp_full |=> state_q == S_EXEC)
        else $error("group overfilled");
endmodule
`default_nettype wire

// [qste_engine_test.sv]
/*
 self-checking bench: table of single-head periodic passes, then an
 async ring pass and a reset in mid pass. assumes the memory model.
*/
`timescale 1ns/100ps
`default_nettype none
module qste_engine_test;
    import qste_pkg::*;
    typedef struct packed {
        logic [7:0] f; // act inact react halt flow newzone unav dis
        logic tdact;
        logic ok;
        logic rflow;
        logic add;
        logic [3:0] cur;
        logic [3:0] ecur;
    } qste_row_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b0;
    logic start = 1'b0;
    logic start_async = 1'b0;
    qste_link_t zone_link = '{32'h40, 1'b0, 1'b0, 8'h03};
    logic [7:0] zone_num = 8'h05;
    logic async_ptr_wr = 1'b0;
    qste_link_t async_ptr_wdata = '0;
    qste_link_t async_list_pointer_reg;
    logic [DEV_N-1:0] dev_unavail = '0;
    logic [DEV_N-1:0] dev_disabled = '0;
    logic req_valid, req_ready, resp_valid, act_valid, grp_start;
    logic busy, pass_done, res_ready;
    qste_req_t req;
    qste_resp_t resp;
    qste_ent_t act_ent;
    logic [IDX_W-1:0] grp_count;
    logic res_valid = 1'b0;
    qste_res_t res = '0;
    logic grp_end = 1'b0;
    qste_qh_t qh_cfg = '0;
    qste_td_t td_cfg = '0;
    logic [3:0] lat = 4'h0;
    qste_req_t last_ovl, last_res;
    logic [7:0] td_idx, qh_reads, q0;
    int fail_count = 0;
    int comparisons = 0;
    int acts = 0;
    int dones = 0;
    qste_row_t rows [13];

    qste_engine qste_engine_i
    (
        .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .start(start),
        .start_async(start_async), .zone_link(zone_link),
        .zone_num(zone_num), .async_ptr_wr(async_ptr_wr),
        .async_ptr_wdata(async_ptr_wdata),
        .async_list_pointer_reg(async_list_pointer_reg),
        .dev_unavail(dev_unavail), .dev_disabled(dev_disabled),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp(resp), .act_valid(act_valid),
        .act_ent(act_ent), .grp_start(grp_start), .grp_count(grp_count),
        .res_valid(res_valid), .res(res), .res_ready(res_ready),
        .grp_end(grp_end), .busy(busy), .pass_done(pass_done)
    );
    qste_mem_model qste_mem_model_i
    (
        .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp),
        .qh_cfg(qh_cfg), .td_cfg(td_cfg), .lat(lat),
        .last_ovl(last_ovl), .last_res(last_res), .td_idx(td_idx),
        .qh_reads(qh_reads)
    );

    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        if (act_valid === 1'b1)
            acts++;
        if (pass_done === 1'b1)
            dones++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want)
        begin
            fail_count++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, want);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_ready();
        for (int n = 0; n < 50 && res_ready !== 1'b1; n++)
            @(negedge sys_clk);
    endtask
    task automatic exec_group(input qste_row_t r);
        res = '0;
        res.txn = 1'b1;
        res.done = !r.rflow;
        res.ok = r.ok;
        res.flow = r.rflow;
        res.err = 8'h04;
        res_valid = 1'b1;
        wait_ready();
        @(negedge sys_clk);
        res_valid = 1'b0;
        res = ~res;
        wait_ready();
        grp_end = 1'b1;
        @(negedge sys_clk);
        grp_end = 1'b0;
    endtask
    task automatic run_row(input qste_row_t r);
        int a0;
        int d0;
        logic [IDX_W-1:0] gc = '0;
        @(negedge sys_clk);
        qh_cfg = '0;
        {qh_cfg.active, qh_cfg.inact, qh_cfg.react} = r.f[7:5];
        {qh_cfg.halted, qh_cfg.flow} = r.f[4:3];
        qh_cfg.periodic = 1'b1;
        qh_cfg.max_cnt = 8'h01;
        qh_cfg.zone = r.f[2] ? 8'h06 : 8'h05;
        qh_cfg.dev = 4'h2;
        qh_cfg.cur = {4'h0, r.cur};
        qh_cfg.status = 8'h01;
        qh_cfg.next.term = 1'b1;
        qh_cfg.ctrl = 1'b1;
        qh_cfg.burst = 5'h04;
        dev_unavail = {13'h0, r.f[1], 2'h0};
        dev_disabled = {13'h0, r.f[0], 2'h0};
        td_cfg = '0;
        td_cfg.active = r.tdact;
        td_cfg.dw0 = 32'h0000_00a5;
        a0 = acts;
        d0 = dones;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        for (int n = 0; n < 400 && dones == d0; n++)
        begin
            @(negedge sys_clk);
            if (grp_start === 1'b1)
            begin
                // the count is cleared when the group ends
                gc = grp_count;
                exec_group(r);
            end
        end
        check(32'(acts - a0), 32'(r.add));
        check(32'(dones - d0), 32'h1);
        if (r.f[7:6] == 2'b00)
            check(32'(td_idx), 32'(r.cur));
        if (r.tdact)
        begin
            check(32'(last_ovl.ovl.full), 32'(!r.f[5]));
            check(last_ovl.ovl.dw0, 32'h0000_00a5);
        end
        if (r.tdact && !r.f[5])
            check(last_ovl.ovl.window, 32'h0000_000f);
        if (r.add)
        begin
            check(32'(gc), 32'h1);
            check(32'(act_ent.cur), 32'(r.cur));
            check(32'(last_res.wb.cur), 32'(r.ecur));
            check(32'(last_res.wb.halt), 32'(!r.ok));
            check(32'(last_res.wb.flow), 32'(r.rflow));
            check(32'(last_res.wb.status), 32'h05);
        end
    endtask

    initial
    begin
        rst = 1'b1;
        rows = '{20'h80_5_1_2, 20'h80_5_3_0, 20'h00_d_2_3, 20'h20_d_0_1,
            20'h00_4_1_1, 20'h40_4_1_1, 20'h90_4_1_1, 20'h88_4_1_1,
            20'h8c_5_1_2, 20'h82_4_1_1, 20'h81_4_1_1, 20'h80_1_1_1,
            20'h80_7_1_1};
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        for (int i = 0; i < 13; i++)
        begin
            // latency 0, 3 and 6 gives prompt and slow memory
            lat = 4'(i % 3 * 3);
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        async_ptr_wr = 1'b1;
        async_ptr_wdata = '{32'h100, 1'b0, 1'b0, 8'h03};
        @(negedge sys_clk);
        async_ptr_wr = 1'b0;
        {qh_cfg.active, qh_cfg.inact, qh_cfg.periodic} = 3'b010;
        qh_cfg.next.term = 1'b0;
        q0 = qh_reads;
        start = 1'b1;
        start_async = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        start_async = 1'b0;
        for (int n = 0; n < 400 && busy === 1'b1; n++)
            @(negedge sys_clk);
        check(32'(qh_reads - q0), 32'h2);
        check(async_list_pointer_reg.ptr, 32'h100);
        $display("async ring done");
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst = 1'b1;
        @(negedge sys_clk);
        check({busy, req_valid, act_valid, pass_done}, 32'h0);
        check(async_list_pointer_reg.ptr, 32'h0);
        rst = 1'b0;
        run_row(rows[0]);
        $display("reset test done");
        conclude();
    end
    // fifteen passes take well under 400 cycles each
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire

// [qste_judge.sv]
/*
 candidate check for one fetched queue head, plus overlay kind.
 assumes the head and device tables are stable while it is read.
*/
`timescale 1ns/100ps
`default_nettype none
module qste_judge
(
    input wire qste_pkg::qste_qh_t qh,
    input wire logic link_iso,
    input wire logic is_async,
    input wire logic [7:0] zone,
    input wire logic [qste_pkg::DEV_N-1:0] dev_unavail,
    input wire logic [qste_pkg::DEV_N-1:0] dev_disabled,
    output logic cand,
    output logic first,
    output logic blank_need,
    output logic iso
);
    import qste_pkg::*;
    logic [7:0] tx;
    logic flow;
    logic bdone;
    logic maxed;

    always_comb
    begin
        // async list heads are always general overlay
        iso = link_iso && !is_async;
        first = qh.periodic && (qh.zone != zone);
        tx = first ? 8'h00 : qh.tx_cnt;
        flow = first ? 1'b0 : qh.flow;
        bdone = first ? 1'b0 : qh.blank_done;
        maxed = qh.periodic && (tx >= qh.max_cnt);
        blank_need = maxed && qh.dir_in && !bdone;
        cand = !dev_unavail[qh.dev] && !dev_disabled[qh.dev]
            && !(!qh.active && qh.inact && !qh.react)
            && !(!iso && qh.halted && !qh.react)
            && !flow && !(maxed && !blank_need);
    end
endmodule
`default_nettype wire

// [qste_mem.sv]
/*
 small active-list store with registered read data.
 assumes one write and one read port on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module qste_mem
#(
    parameter int W = 8,
    parameter int DEPTH = 16
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk)
    begin
        if (clk_en && we)
            mem[waddr] <= wdata;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rdata <= '0;
        else if (clk_en)
            rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// [qste_mem_model.sv]
/*
 memory agent model: serves head and descriptor reads after a set
 latency and records writes. assumes the engine's req/resp contract.
*/
`timescale 1ns/100ps
`default_nettype none
module qste_mem_model
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire qste_pkg::qste_req_t req,
    output logic req_ready,
    output logic resp_valid,
    output qste_pkg::qste_resp_t resp,
    input wire qste_pkg::qste_qh_t qh_cfg,
    input wire qste_pkg::qste_td_t td_cfg,
    input wire logic [3:0] lat,
    output qste_pkg::qste_req_t last_ovl,
    output qste_pkg::qste_req_t last_res,
    output logic [7:0] td_idx,
    output logic [7:0] qh_reads
);
    import qste_pkg::*;
    logic pend_q;
    logic [3:0] wait_q;
    logic [31:0] addr_q;
    // one read outstanding, so accept only while idle
    assign req_ready = req_valid && !pend_q;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pend_q <= 1'b0;
            wait_q <= 4'h0;
            addr_q <= 32'h0;
            resp_valid <= 1'b0;
            resp <= '0;
            last_ovl <= '0;
            last_res <= '0;
            td_idx <= 8'h00;
            qh_reads <= 8'h00;
        end
        else
        begin
            resp_valid <= 1'b0;
            // released data is scrambled so a stale value never matches
            if (resp_valid)
                resp <= ~resp;
            if (req_valid && req_ready)
            begin
                pend_q <= (req.op == OP_RD_QH) || (req.op == OP_RD_TD);
                wait_q <= lat;
                addr_q <= req.addr;
                if (req.op == OP_RD_QH)
                    qh_reads <= qh_reads + 8'h01;
                if (req.op == OP_RD_TD)
                    td_idx <= req.idx;
                if (req.op == OP_WR_OVL)
                    last_ovl <= req;
                if (req.op == OP_WR_RES)
                    last_res <= req;
            end
            else if (pend_q && wait_q != 4'h0)
                wait_q <= wait_q - 4'h1;
            else if (pend_q)
            begin
                pend_q <= 1'b0;
                resp_valid <= 1'b1;
                resp.qh <= qh_cfg;
                // heads alternate between two addresses: a ring of two
                resp.qh.next.ptr <= addr_q ^ 32'h100;
                resp.td <= td_cfg;
            end
        end
    end
endmodule
`default_nettype wire

// [qste_pkg.sv]
/*
 shared layouts, memory request ops and reset constants for the queue
 set traversal engine. assumes nothing of its surroundings.
*/
package qste_pkg;
    localparam int IDX_W = 4;
    localparam int DEV_N = 16;
    localparam int MAX_GRP = 8;
    localparam logic [7:0] IDX_RST = 8'h00;
    localparam logic [7:0] SEQ_RST = 8'h00;
    localparam logic [7:0] ZONE_RST = 8'h00;
    localparam logic [IDX_W-1:0] CNT_RST = 4'h0;
    localparam logic [15:0] PRES_STEP = 16'h0001;

    typedef enum logic [1:0] {OP_RD_QH, OP_RD_TD, OP_WR_OVL, OP_WR_RES}
        qste_op_t;

    typedef struct packed {
        logic [31:0] ptr;
        logic term;
        logic iso;
        logic [7:0] count;
    } qste_link_t;

    typedef struct packed {
        qste_link_t next;
        logic active;
        logic inact;
        logic react;
        logic halted;
        logic flow;
        logic periodic;
        logic dir_in;
        logic ctrl;
        logic blank_done;
        logic [4:0] burst;
        logic [7:0] max_cnt;
        logic [7:0] tx_cnt;
        logic [7:0] zone;
        logic [3:0] dev;
        logic [7:0] cur;
        logic [7:0] status;
        logic [15:0] pres;
    } qste_qh_t;

    typedef struct packed {
        logic active;
        logic [31:0] dw0;
        logic [63:0] body;
        logic [15:0] pres;
    } qste_td_t;

    typedef struct packed {
        logic full;
        logic win_rst;
        logic setup;
        logic [31:0] dw0;
        logic [63:0] body;
        logic [31:0] window;
        logic [7:0] seq;
        logic [15:0] pres;
    } qste_ovl_t;

    typedef struct packed {
        logic [31:0] qs;
        logic [7:0] td;
        logic [7:0] cur;
        logic [7:0] status;
        logic [7:0] tx_cnt;
        logic [7:0] zone;
        logic done;
        logic halt;
        logic flow;
        logic blank_done;
    } qste_wb_t;

    typedef struct packed {
        qste_op_t op;
        logic [31:0] addr;
        logic [7:0] idx;
        logic iso;
        qste_ovl_t ovl;
        qste_wb_t wb;
    } qste_req_t;

    typedef struct packed {
        qste_qh_t qh;
        qste_td_t td;
    } qste_resp_t;

    typedef struct packed {
        logic [31:0] qs;
        logic [7:0] count;
        logic [7:0] cur;
        logic [7:0] status;
        logic [7:0] tx_cnt;
        logic [7:0] max_cnt;
        logic periodic;
        logic dir_in;
        logic blank;
        logic blank_done;
        logic iso;
    } qste_ent_t;

    typedef struct packed {
        logic [IDX_W-1:0] idx;
        logic txn;
        logic done;
        logic ok;
        logic flow;
        logic [7:0] err;
    } qste_res_t;

    function automatic logic [31:0] low_ones(input logic [4:0] n);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 32; i++)
            m[i] = (i < n);
        return m;
    endfunction
endpackage
